/* File: rtl/uesc_defs.svh */
// Register offsets, field positions, reset values and timing constants of the error/status block.
`ifndef UESC_DEFS_SVH
`define UESC_DEFS_SVH

`define UESC_OFS_ERR_FLAGS   12'h000
`define UESC_OFS_ERR_ENABLES 12'h004
`define UESC_OFS_STATUS      12'h008
`define UESC_OFS_CONTROL     12'h00c
`define UESC_OFS_INT_FLAGS   12'h010
`define UESC_OFS_INT_ENABLES 12'h014

`define UESC_ERR_PID      0
`define UESC_ERR_CRC5_EOF 1
`define UESC_ERR_CRC16    2
`define UESC_ERR_FSIZE    3
`define UESC_ERR_BTO      4
`define UESC_ERR_DMA      5
`define UESC_ERR_BMX      6
`define UESC_ERR_STUFF    7

`define UESC_ST_ODD       2
`define UESC_ST_DIR       3
`define UESC_ST_EP_LSB    4
`define UESC_ST_EP_MSB    7

`define UESC_CON_EN       0
`define UESC_CON_PINGPONG_POINTER_RESET   1
`define UESC_CON_RESUME   2
`define UESC_CON_HOST_ROLE_ENABLE   3
`define UESC_CON_BUS_RESET_DRIVE   4
`define UESC_CON_PACKET_PROCESSING_DISABLE   5
`define UESC_CON_SE0      6
`define UESC_CON_LIVE_J_LINE_FLAG   7

`define UESC_INT_ERR      1
`define UESC_INT_TRN      3

`define UESC_RST_BYTE     8'h00
`define UESC_RST_WORD     32'h0000_0000
`define UESC_QUEUE_DEPTH  4
`define UESC_BTO_BITS     16
`define UESC_CLK_PERIOD_NS 25
`define UESC_SOF_PERIOD_NS 1000000
`define UESC_SOF_CYCLES   (`UESC_SOF_PERIOD_NS / `UESC_CLK_PERIOD_NS)

`endif

/* File: rtl/uesc_pkg.sv */
// Types shared by the error/status/control block.
package uesc_pkg;
  typedef logic [7:0] uesc_byte_t;
  typedef logic [5:0] uesc_entry_t;
  typedef enum logic [1:0] {UESC_BTO_IDLE, UESC_BTO_WAIT, UESC_BTO_DONE} uesc_bto_t;
endpackage

/* File: rtl/uesc_top.sv */
// Error flags, transaction status queue and module control for a dual-role USB controller.
`timescale 1ns/1ps
`include "uesc_defs.svh"

module uesc_top
  import uesc_pkg::*;
#(
  parameter int SOF_CYCLES = `UESC_SOF_CYCLES
)(
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        pid_check_fail,
  input  wire logic        token_crc_fail,
  input  wire logic        data_crc_fail,
  input  wire logic        field_size_fail,
  input  wire logic        stuffing_fail,
  input  wire logic        bus_matrix_fail,
  input  wire logic        dma_grant_late,
  input  wire logic        buffer_truncated,
  input  wire logic        link_busy,
  input  wire logic        frame_count_zero,
  input  wire logic        eop_seen,
  input  wire logic        response_seen,
  input  wire logic        bit_tick,
  input  wire logic        token_done,
  input  wire logic [3:0]  token_done_endpoint,
  input  wire logic        token_done_tx,
  input  wire logic        token_done_odd,
  input  wire logic        setup_token_seen,
  input  wire logic        token_in_progress,
  input  wire logic        line_j_pin,
  input  wire logic        line_se0_pin,
  output logic             module_cpu_interrupt_flag,
  output logic             module_enable,
  output logic             packet_processing_disable,
  output logic             bus_reset_drive,
  output logic             host_role_enable,
  output logic             host_logic_reset,
  output logic             resume_drive,
  output logic             low_speed_eop_send,
  output logic             pingpong_pointer_reset,
  output logic             frame_token_send
);

  // Register state.
  uesc_byte_t  err_flags_ff;
  uesc_byte_t  err_en_ff;
  logic        err_summary_ff;
  logic        err_summary_en_ff;
  logic        tok_flag_ff;
  logic [5:0]  con_ff;
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic        irq_ff;
  logic        host_rst_ff;
  logic        ls_eop_ff;
  logic        sof_send_ff;
  logic [2:0]  j_sync_ff;
  logic [2:0]  se0_sync_ff;
  logic        j_live_ff;
  logic        se0_live_ff;
  uesc_entry_t queue_ff [`UESC_QUEUE_DEPTH];
  logic [1:0]  rd_ptr_ff;
  logic [1:0]  wr_ptr_ff;
  logic [2:0]  count_ff;
  uesc_bto_t   bto_state_ff;
  logic [4:0]  bto_bits_ff;
  logic [15:0] sof_cnt_ff;

  // Bus decode: writes take effect at the access edge; read data is captured at the end of the setup cycle.
  logic        acc;
  logic        wr_acc;
  logic        setup;
  logic        hit;
  logic        host_mode;
  assign acc       = psel & penable & pready_ff;
  assign wr_acc    = acc & pwrite;
  assign setup     = psel & ~penable;
  assign host_mode = con_ff[`UESC_CON_HOST_ROLE_ENABLE];
  assign hit       = (paddr == `UESC_OFS_ERR_FLAGS) | (paddr == `UESC_OFS_ERR_ENABLES)
                   | (paddr == `UESC_OFS_STATUS) | (paddr == `UESC_OFS_CONTROL)
                   | (paddr == `UESC_OFS_INT_FLAGS) | (paddr == `UESC_OFS_INT_ENABLES);

  logic wr_eflags;
  logic wr_een;
  logic wr_con;
  logic wr_iflags;
  logic wr_ien;
  assign wr_eflags = wr_acc & (paddr == `UESC_OFS_ERR_FLAGS);
  assign wr_een    = wr_acc & (paddr == `UESC_OFS_ERR_ENABLES);
  assign wr_con    = wr_acc & (paddr == `UESC_OFS_CONTROL);
  assign wr_iflags = wr_acc & (paddr == `UESC_OFS_INT_FLAGS);
  assign wr_ien    = wr_acc & (paddr == `UESC_OFS_INT_ENABLES);

  // Error events in flag order; the CRC5 slot changes meaning with the role.
  logic       bto_evt;
  uesc_byte_t err_evt;
  assign err_evt[`UESC_ERR_PID]      = pid_check_fail;
  assign err_evt[`UESC_ERR_CRC5_EOF] = host_mode ? (link_busy & frame_count_zero)
                                                 : token_crc_fail;
  assign err_evt[`UESC_ERR_CRC16]    = data_crc_fail;
  assign err_evt[`UESC_ERR_FSIZE]    = field_size_fail;
  assign err_evt[`UESC_ERR_BTO]      = bto_evt;
  assign err_evt[`UESC_ERR_DMA]      = dma_grant_late | buffer_truncated;
  assign err_evt[`UESC_ERR_BMX]      = bus_matrix_fail;
  assign err_evt[`UESC_ERR_STUFF]    = stuffing_fail;

  // Per-bit sticky flags; an event in the clearing cycle survives.
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_err
      always_ff @(posedge clk_sys)
      begin
        if (!reset_n)
          err_flags_ff[gi] <= 1'b0;
        else if (err_evt[gi])
          err_flags_ff[gi] <= 1'b1;
        else if (wr_eflags && pwdata[gi])
          err_flags_ff[gi] <= 1'b0;
      end
    end
  endgenerate

  // Enable registers.
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      err_en_ff         <= `UESC_RST_BYTE;
      err_summary_en_ff <= 1'b0;
    end
    else
    begin
      if (wr_een)
        err_en_ff <= pwdata[7:0];
      if (wr_ien)
        err_summary_en_ff <= pwdata[`UESC_INT_ERR];
    end
  end

  // Summary error flag: only enabled error events set it, set beats clear.
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      err_summary_ff <= 1'b0;
    else if (|(err_evt & err_en_ff))
      err_summary_ff <= 1'b1;
    else if (wr_iflags && pwdata[`UESC_INT_ERR])
      err_summary_ff <= 1'b0;
  end

  // Processor interrupt follows the summary flag only when it is enabled.
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      irq_ff <= 1'b0;
    else
      irq_ff <= err_summary_ff & err_summary_en_ff;
  end

  // Turnaround watch: counts bit-times after an EOP until a response arrives.
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      bto_state_ff <= UESC_BTO_IDLE;
      bto_bits_ff  <= 5'h00;
    end
    else
    begin
      case (bto_state_ff)
        UESC_BTO_IDLE:
        begin
          if (eop_seen)
          begin
            bto_state_ff <= UESC_BTO_WAIT;
            bto_bits_ff  <= 5'h00;
          end
        end
        UESC_BTO_WAIT:
        begin
          if (response_seen)
            bto_state_ff <= UESC_BTO_IDLE;
          else if (bit_tick)
          begin
            bto_bits_ff <= bto_bits_ff + 5'h01;
            if (bto_bits_ff == 5'(`UESC_BTO_BITS))
              bto_state_ff <= UESC_BTO_DONE;
          end
        end
        UESC_BTO_DONE:
          bto_state_ff <= UESC_BTO_IDLE;
        default:
          bto_state_ff <= UESC_BTO_IDLE;
      endcase
    end
  end
  assign bto_evt = (bto_state_ff == UESC_BTO_DONE);

  // Status queue: push on token completion, pop on clearing the completion flag.
  logic pop;
  logic push;
  assign pop  = wr_iflags & pwdata[`UESC_INT_TRN] & (count_ff != 3'h0);
  assign push = token_done & (count_ff != 3'(`UESC_QUEUE_DEPTH));

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      rd_ptr_ff <= 2'h0;
      wr_ptr_ff <= 2'h0;
      count_ff  <= 3'h0;
    end
    else
    begin
      if (push)
        wr_ptr_ff <= wr_ptr_ff + 2'h1;
      if (pop)
        rd_ptr_ff <= rd_ptr_ff + 2'h1;
      if (push && !pop)
        count_ff <= count_ff + 3'h1;
      else if (pop && !push)
        count_ff <= count_ff - 3'h1;
    end
  end

  // Entry storage; no reset needed since contents are invalid while empty.
  always_ff @(posedge clk_sys)
  begin
    if (push)
      queue_ff[wr_ptr_ff] <= {token_done_endpoint, token_done_tx, token_done_odd};
  end

  // Completion flag shows that a valid head entry stands; a push in the pop cycle keeps it.
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      tok_flag_ff <= 1'b0;
    else if (push)
      tok_flag_ff <= 1'b1;
    else if (pop)
      tok_flag_ff <= (count_ff != 3'h1);
  end

  // Line inputs come from pins: three stages, a change counts once stages two and three agree.
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      j_sync_ff   <= 3'h0;
      se0_sync_ff <= 3'h0;
      j_live_ff   <= 1'b0;
      se0_live_ff <= 1'b0;
    end
    else
    begin
      j_sync_ff   <= {j_sync_ff[1:0], line_j_pin};
      se0_sync_ff <= {se0_sync_ff[1:0], line_se0_pin};
      if (j_sync_ff[1] == j_sync_ff[2])
        j_live_ff <= j_sync_ff[2];
      if (se0_sync_ff[1] == se0_sync_ff[2])
        se0_live_ff <= se0_sync_ff[2];
    end
  end

  // Control bits; in device mode the SETUP token forces packet disable over a software clear.
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      con_ff <= 6'h00;
    else
    begin
      if (wr_con)
        con_ff <= pwdata[5:0];
      if (!host_mode && setup_token_seen)
        con_ff[`UESC_CON_PACKET_PROCESSING_DISABLE] <= 1'b1;
    end
  end

  // Host-logic reset pulses on every change of the host enable bit.
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      host_rst_ff <= 1'b0;
      ls_eop_ff   <= 1'b0;
    end
    else
    begin
      host_rst_ff <= wr_con & (pwdata[`UESC_CON_HOST_ROLE_ENABLE] != host_mode);
      ls_eop_ff   <= wr_con & host_mode & con_ff[`UESC_CON_RESUME]
                   & ~pwdata[`UESC_CON_RESUME];
    end
  end

  // Frame token timer runs only in host mode with frame tokens enabled.
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      sof_cnt_ff  <= 16'h0000;
      sof_send_ff <= 1'b0;
    end
    else if (host_mode && con_ff[`UESC_CON_EN] && !host_rst_ff)
    begin
      sof_send_ff <= (sof_cnt_ff == 16'(SOF_CYCLES - 1));
      if (sof_cnt_ff == 16'(SOF_CYCLES - 1))
        sof_cnt_ff <= 16'h0000;
      else
        sof_cnt_ff <= sof_cnt_ff + 16'h0001;
    end
    else
    begin
      sof_cnt_ff  <= 16'h0000;
      sof_send_ff <= 1'b0;
    end
  end

  // Read data and answer are prepared in the setup cycle, so every access takes no wait.
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = `UESC_RST_WORD;
    case (paddr)
      `UESC_OFS_ERR_FLAGS:   rd_mux[7:0] = err_flags_ff;
      `UESC_OFS_ERR_ENABLES: rd_mux[7:0] = err_en_ff;
      `UESC_OFS_STATUS:
        if (tok_flag_ff)
          rd_mux[`UESC_ST_EP_MSB:`UESC_ST_ODD] = queue_ff[rd_ptr_ff];
      `UESC_OFS_CONTROL:
      begin
        rd_mux[5:0]              = con_ff;
        rd_mux[`UESC_CON_PACKET_PROCESSING_DISABLE] = host_mode ? token_in_progress
                                             : con_ff[`UESC_CON_PACKET_PROCESSING_DISABLE];
        rd_mux[`UESC_CON_SE0]    = se0_live_ff;
        rd_mux[`UESC_CON_LIVE_J_LINE_FLAG] = j_live_ff;
      end
      `UESC_OFS_INT_FLAGS:
      begin
        rd_mux[`UESC_INT_ERR] = err_summary_ff;
        rd_mux[`UESC_INT_TRN] = tok_flag_ff;
      end
      `UESC_OFS_INT_ENABLES: rd_mux[`UESC_INT_ERR] = err_summary_en_ff;
      default:               rd_mux = `UESC_RST_WORD;
    endcase
  end

  // Bus answer registers.
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      prdata_ff  <= `UESC_RST_WORD;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end
    else
    begin
      pready_ff  <= setup;
      pslverr_ff <= setup & ~hit;
      if (setup && !pwrite)
        prdata_ff <= rd_mux;
    end
  end

  assign prdata                    = prdata_ff;
  assign pready                    = pready_ff;
  assign pslverr                   = pslverr_ff;
  assign module_cpu_interrupt_flag = irq_ff;
  assign module_enable             = con_ff[`UESC_CON_EN] & ~host_mode;
  assign packet_processing_disable = con_ff[`UESC_CON_PACKET_PROCESSING_DISABLE] & ~host_mode;
  assign bus_reset_drive           = con_ff[`UESC_CON_BUS_RESET_DRIVE] & host_mode;
  assign host_role_enable          = host_mode;
  assign host_logic_reset          = host_rst_ff;
  assign resume_drive              = con_ff[`UESC_CON_RESUME];
  assign low_speed_eop_send        = ls_eop_ff;
  assign pingpong_pointer_reset    = con_ff[`UESC_CON_PINGPONG_POINTER_RESET];
  assign frame_token_send          = sof_send_ff;

  // Checks on the block's own behaviour.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  property p_crc5_set;
    !host_mode && token_crc_fail |=> err_flags_ff[`UESC_ERR_CRC5_EOF];
  endproperty
  a_crc5_set: assert property (p_crc5_set) else $error("crc5 flag not set");

  property p_eof_set;
    host_mode && link_busy && frame_count_zero |=> err_flags_ff[`UESC_ERR_CRC5_EOF];
  endproperty
  a_eof_set: assert property (p_eof_set) else $error("eof flag not set");

  property p_pid_set;
    pid_check_fail |=> err_flags_ff[`UESC_ERR_PID];
  endproperty
  a_pid_set: assert property (p_pid_set) else $error("pid flag not set");

  property p_dma_set;
    (dma_grant_late || buffer_truncated) |=> err_flags_ff[`UESC_ERR_DMA];
  endproperty
  a_dma_set: assert property (p_dma_set) else $error("dma flag not set");

  property p_bto_wait;
    bto_evt |-> $past(bto_bits_ff) == 5'(`UESC_BTO_BITS) && !$past(response_seen);
  endproperty
  a_bto_wait: assert property (p_bto_wait) else $error("turnaround flag early");

  property p_summary_cause;
    $rose(err_summary_ff) |-> $past(|(err_evt & err_en_ff));
  endproperty
  a_summary_cause: assert property (p_summary_cause) else $error("summary from masked");

  property p_irq_gate;
    irq_ff |-> $past(err_summary_ff) && $past(err_summary_en_ff);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without enable");

  property p_flag_count;
    tok_flag_ff == (count_ff != 3'h0);
  endproperty
  a_flag_count: assert property (p_flag_count) else $error("flag and queue disagree");

  property p_setup_disable;
    !host_mode && setup_token_seen ##1 !host_mode |-> packet_processing_disable;
  endproperty
  a_setup_disable: assert property (p_setup_disable) else $error("packet_processing_disable not set");

  property p_host_reset;
    wr_con && (pwdata[`UESC_CON_HOST_ROLE_ENABLE] != host_mode) |=> host_logic_reset ##1 !host_logic_reset;
  endproperty
  a_host_reset: assert property (p_host_reset) else $error("host reset pulse wrong");

  property p_sof_period;
    frame_token_send ##1 (host_mode && con_ff[`UESC_CON_EN])[*8] |-> !frame_token_send;
  endproperty
  a_sof_period: assert property (p_sof_period) else $error("frame token too soon");

  c_queue_full: cover property (count_ff == 3'(`UESC_QUEUE_DEPTH));
  c_push_pop:   cover property (push && pop);
  c_irq:        cover property ($rose(module_cpu_interrupt_flag));
  c_bto:        cover property (bto_evt);

endmodule // uesc_top

/* File: test/uesc_link_model.sv */
// Far-side link model: bit-time ticks and live line levels.
`timescale 1ns/1ps
module uesc_link_model #(
  parameter int TICK_CYCLES = 8
)(
  input  wire logic clk_sys,
  input  wire logic bus_reset_drive,
  output logic      bit_tick,
  output logic      line_j_pin,
  output logic      line_se0_pin
);
  int cnt = 0;

  // A slow bit-time tick leaves room to probe between the 16th and 17th tick.
  always @(posedge clk_sys)
  begin
    cnt      <= (cnt == TICK_CYCLES - 1) ? 0 : cnt + 1;
    bit_tick <= (cnt == 0);
  end

  // The idle bus shows J; while reset signalling is driven the line sits in SE0.
  assign line_j_pin   = !bus_reset_drive;
  assign line_se0_pin = bus_reset_drive;
endmodule // uesc_link_model

/* File: test/test_usb_error_status_control.sv */
// Self-checking bench for the error, status queue and control block.
`timescale 1ns/1ps
`include "uesc_defs.svh"
module test_usb_error_status_control;
  logic        clk_sys, reset_n, psel, penable, pwrite, pready, pslverr, serr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  ev;
  logic [3:0]  tep;
  logic        lbusy, fzero, eop, resp, tdone, ttx, todd, setup, tip, bt, lj, lse0;
  logic        cpu_int, men, pkd, brd, hre, hlr, rsm, lseop, ppr, fts;
  int          n_errors = 0, compares = 0, cyc = 0, n_hlr = 0, n_lse = 0, n_sof = 0, n;

  uesc_top #(.SOF_CYCLES(20)) i_dut (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pid_check_fail(ev[0]), .token_crc_fail(ev[1]),
    .data_crc_fail(ev[2]), .field_size_fail(ev[3]), .buffer_truncated(ev[4]),
    .dma_grant_late(ev[5]), .bus_matrix_fail(ev[6]), .stuffing_fail(ev[7]),
    .link_busy(lbusy), .frame_count_zero(fzero), .eop_seen(eop), .response_seen(resp),
    .bit_tick(bt), .token_done(tdone), .token_done_endpoint(tep), .token_done_tx(ttx),
    .token_done_odd(todd), .setup_token_seen(setup), .token_in_progress(tip),
    .line_j_pin(lj), .line_se0_pin(lse0), .module_cpu_interrupt_flag(cpu_int),
    .module_enable(men), .packet_processing_disable(pkd), .bus_reset_drive(brd),
    .host_role_enable(hre), .host_logic_reset(hlr), .resume_drive(rsm),
    .low_speed_eop_send(lseop), .pingpong_pointer_reset(ppr), .frame_token_send(fts));

  uesc_link_model #(.TICK_CYCLES(8)) i_link (.clk_sys(clk_sys), .bus_reset_drive(brd),
    .bit_tick(bt), .line_j_pin(lj), .line_se0_pin(lse0));

  // Free-running 40 MHz clock.
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // Pulse counters and the hang limit share one clocked process.
  always @(posedge clk_sys)
  begin
    cyc++;
    if (hlr === 1'b1) n_hlr++;
    if (lseop === 1'b1) n_lse++;
    if (fts === 1'b1) n_sof++;
    if (cyc == 20000)
    begin
      n_errors++;
      stop_test();
    end
  end

  task stop_test;
    $display("errors=%0d compares=%0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // The request is held until pready is seen at a rising edge, whatever the wait.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, e);
  endtask

  task w2;
    repeat (2) @(posedge clk_sys);
  endtask

  task pulse_ev(input logic [7:0] v);
    @(posedge clk_sys);
    ev <= v;
    @(posedge clk_sys);
    ev <= 8'h00;
  endtask

  task t_reset;
    repeat (5) @(posedge clk_sys);
    for (int a = 0; a < 6; a++)
      rdchk(12'(a * 4), (a == 3) ? 32'h0000_0080 : 32'h0000_0000);
    apb(1'b0, 12'h018, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk(serr, 1'b1);
    apb(1'b1, `UESC_OFS_STATUS, 32'h0000_00ff);
    rdchk(`UESC_OFS_STATUS, 32'h0000_0000);
  endtask

  // Each of the eight error inputs in turn, all masked, so the summary must stay quiet.
  task t_errors;
    logic [31:0] e;
    for (int i = 0; i < 8; i++)
    begin
      e = (i == 4) ? 32'h0000_0020 : 32'h0000_0001 << i;
      pulse_ev(8'h01 << i);
      w2();
      rdchk(`UESC_OFS_ERR_FLAGS, e);
      rdchk(`UESC_OFS_INT_FLAGS, 32'h0000_0000);
      apb(1'b1, `UESC_OFS_ERR_FLAGS, e);
      rdchk(`UESC_OFS_ERR_FLAGS, 32'h0000_0000);
    end
  endtask

  task t_irq;
    apb(1'b1, `UESC_OFS_ERR_ENABLES, 32'h0000_0001);
    rdchk(`UESC_OFS_ERR_ENABLES, 32'h0000_0001);
    pulse_ev(8'h04);
    w2();
    rdchk(`UESC_OFS_INT_FLAGS, 32'h0000_0000);
    pulse_ev(8'h01);
    w2();
    rdchk(`UESC_OFS_INT_FLAGS, 32'h0000_0002);
    chk(cpu_int, 1'b0);
    apb(1'b1, `UESC_OFS_INT_ENABLES, 32'h0000_0002);
    w2();
    chk(cpu_int, 1'b1);
    apb(1'b1, `UESC_OFS_ERR_FLAGS, 32'h0000_0005);
    apb(1'b1, `UESC_OFS_INT_FLAGS, 32'h0000_0002);
    w2();
    chk(cpu_int, 1'b0);
  endtask

  // A response after five bit-times cancels the watch, so twenty quiet ticks later no flag stands.
  // Then the end of packet is placed right after a tick so the count is unambiguous.
  task t_turn;
    @(posedge clk_sys);
    eop <= 1'b1;
    @(posedge clk_sys);
    eop <= 1'b0;
    repeat (40) @(posedge clk_sys);
    resp <= 1'b1;
    @(posedge clk_sys);
    resp <= 1'b0;
    repeat (160) @(posedge clk_sys);
    rdchk(`UESC_OFS_ERR_FLAGS, 32'h0000_0000);
    do @(posedge clk_sys); while (bt !== 1'b1);
    eop <= 1'b1;
    @(posedge clk_sys);
    eop <= 1'b0;
    n = 0;
    while (n < 16)
    begin
      @(posedge clk_sys);
      if (bt === 1'b1) n++;
    end
    rdchk(`UESC_OFS_ERR_FLAGS, 32'h0000_0000);
    do @(posedge clk_sys); while (bt !== 1'b1);
    repeat (3) @(posedge clk_sys);
    rdchk(`UESC_OFS_ERR_FLAGS, 32'h0000_0010);
    apb(1'b1, `UESC_OFS_ERR_FLAGS, 32'h0000_0010);
  endtask

  // Five pushes into four places: the last is dropped, the rest pop in order.
  task t_queue;
    for (int i = 0; i < 5; i++)
    begin
      @(posedge clk_sys);
      tdone <= 1'b1;
      tep <= 4'(15 - 5 * i);
      ttx <= i[0];
      todd <= i[1];
      @(posedge clk_sys);
      tdone <= 1'b0;
    end
    for (int i = 0; i < 4; i++)
    begin
      rdchk(`UESC_OFS_INT_FLAGS, 32'h0000_0008);
      rdchk(`UESC_OFS_STATUS, {24'h0, 4'(15 - 5 * i), i[0], i[1], 2'b00});
      apb(1'b1, `UESC_OFS_INT_FLAGS, 32'h0000_0008);
    end
    rdchk(`UESC_OFS_INT_FLAGS, 32'h0000_0000);
    rdchk(`UESC_OFS_STATUS, 32'h0000_0000);
  endtask

  task t_control;
    apb(1'b1, `UESC_OFS_CONTROL, 32'h0000_0001);
    w2();
    chk(men, 1'b1);
    @(posedge clk_sys);
    setup <= 1'b1;
    @(posedge clk_sys);
    setup <= 1'b0;
    w2();
    rdchk(`UESC_OFS_CONTROL, 32'h0000_00a1);
    chk(pkd, 1'b1);
    apb(1'b1, `UESC_OFS_CONTROL, 32'h0000_0003);
    w2();
    chk(ppr, 1'b1);
    apb(1'b1, `UESC_OFS_CONTROL, 32'h0000_0008);
    w2();
    chk({n_hlr[1:0], hre, men}, 4'h6);
    tip <= 1'b1;
    apb(1'b1, `UESC_OFS_CONTROL, 32'h0000_0018);
    repeat (5) @(posedge clk_sys);
    rdchk(`UESC_OFS_CONTROL, 32'h0000_0078);
    chk(brd, 1'b1);
    tip <= 1'b0;
    // Resume is held only a few cycles here; the full hold would overrun the run budget.
    apb(1'b1, `UESC_OFS_CONTROL, 32'h0000_000c);
    w2();
    chk({brd, rsm}, 2'b01);
    apb(1'b1, `UESC_OFS_CONTROL, 32'h0000_0008);
    w2();
    chk(n_lse, 1);
    apb(1'b1, `UESC_OFS_CONTROL, 32'h0000_0009);
    n = 0;
    while (fts !== 1'b1 && n < 60)
    begin
      @(posedge clk_sys);
      n++;
    end
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (fts !== 1'b1 && n < 60);
    chk(n, 20);
    apb(1'b1, `UESC_OFS_CONTROL, 32'h0000_0008);
    w2();
    n = n_sof;
    repeat (60) @(posedge clk_sys);
    chk(n_sof, n);
    @(posedge clk_sys);
    lbusy <= 1'b1;
    fzero <= 1'b1;
    @(posedge clk_sys);
    lbusy <= 1'b0;
    fzero <= 1'b0;
    w2();
    rdchk(`UESC_OFS_ERR_FLAGS, 32'h0000_0002);
    apb(1'b1, `UESC_OFS_CONTROL, 32'h0000_0000);
    w2();
    chk(n_hlr, 2);
  endtask

  // Main sequence: quiet inputs, reset for 12 cycles, then each scenario.
  initial
  begin
    {reset_n, psel, penable, pwrite, paddr, pwdata, ev, tep} = '0;
    {lbusy, fzero, eop, resp, tdone, ttx, todd, setup, tip} = '0;
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_reset();
    t_errors();
    t_irq();
    t_turn();
    t_queue();
    t_control();
    stop_test();
  end
endmodule // test_usb_error_status_control
